// ### hdl/gam_pkg.sv
// package of constants and types for the aux mode configuration block
// assumes one 125 MHz clock and a synchronous active-high reset
// Function
// - prohibit time T1 comes from a counter scaled by reference frequency.
// - receive mode 00 normal, 01 hold rfd each byte, 10 on end, 11 continuous.
// - eos byte sets end flag only while end-on-eos permit is set.
// - with auto-end permit and talker active, send end together with eos byte.
// - eos width bit picks 8-bit or low 7-bit compare.
// - undefined command sets pass-through flag only when detection is permitted.
// - permit bit allows end message while in serial poll active state.
// - fast settle uses short T1 from the second byte, else long T1.
// - polarity bit selects active level of interrupt pin.
// - ist follows service request state when source bit set, else poll flag.
// - clear holdoff enable holds dac false on entering device clear until released.
// - trigger holdoff enable holds dac false on entering device trigger until released.
// - code 011 programs unconfigure, sense, line select; device answers polls so.
// - end-of-string register holds byte compared against data for block end.
// - valid or non-valid aux command releases pending dac holdoff.
package gam_pkg;
  localparam logic [2:0] CODE_AUX_CMD   = 3'h0;
  localparam logic [2:0] CODE_REF_FREQ  = 3'h1;
  localparam logic [2:0] CODE_POLL_CFG  = 3'h3;
  localparam logic [2:0] CODE_REG_A     = 3'h4;
  localparam logic [2:0] CODE_REG_B     = 3'h5;
  localparam logic [2:0] CODE_REG_E     = 3'h6;
  localparam logic [4:0] CMD_NONVALID   = 5'h07;
  localparam logic [4:0] CMD_VALID      = 5'h0F;
  localparam logic [1:0] RX_NORMAL      = 2'h0;
  localparam logic [1:0] RX_HOLD_ALL    = 2'h1;
  localparam logic [1:0] RX_HOLD_END    = 2'h2;
  localparam logic [1:0] RX_CONTINUOUS  = 2'h3;
  localparam logic [4:0] CFG_RESET      = 5'h00;
  localparam logic [3:0] FREQ_RESET     = 4'h0;
  localparam logic [7:0] EOS_RESET      = 8'h00;
  // settle times in ns, long and short T1
  localparam int T1_LONG_NS  = 2000;
  localparam int T1_SHORT_NS = 500;
  localparam int CLK_NS      = 8;
  localparam int T1_LONG_CYC  = (T1_LONG_NS + CLK_NS - 1) / CLK_NS;
  localparam int T1_SHORT_CYC = (T1_SHORT_NS + CLK_NS - 1) / CLK_NS;
  localparam int FIFO_DEPTH  = 8;
  localparam int FIFO_WIDTH  = 9;

  typedef struct packed {
    logic       eos_width_select;
    logic       auto_end_permit;
    logic       end_on_eos_permit;
    logic       receive_mode_high;
    logic       receive_mode_low;
  } gam_reg_a_t;

  typedef struct packed {
    logic       ist_source_select;
    logic       irq_polarity;
    logic       fast_settle_select;
    logic       end_in_poll_permit;
    logic       undefined_cmd_detect;
  } gam_reg_b_t;

  typedef struct packed {
    logic       trigger_holdoff_enable;
    logic       clear_holdoff_enable;
  } gam_reg_e_t;

  typedef struct packed {
    logic       unconfigure;
    logic       sense;
    logic [2:0] poll_line_select;
  } gam_poll_t;

  // byte and end mark travelling through the fifo
  typedef struct packed {
    logic       end_mark;
    logic [7:0] data;
  } gam_byte_t;
endpackage

// ### hdl/gam_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes both sides on sys_clk
`timescale 1ns/10ps
module gam_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
)(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             srst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   count;
  } gam_fifo_st_t;

  gam_fifo_st_t           st;
  gam_fifo_st_t           next_st;
  logic [WIDTH-1:0]       mem [DEPTH];
  logic                   push;
  logic                   pop;

  assign in_ready  = (st.count != DEPTH[AW:0]);
  assign out_valid = (st.count != '0);
  assign out_data  = mem[st.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    next_st = st;
    if (push)
      next_st.wr = st.wr + 1'b1;
    if (pop)
      next_st.rd = st.rd + 1'b1;
    if (push && !pop)
      next_st.count = st.count + 1'b1;
    else if (pop && !push)
      next_st.count = st.count - 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      st <= '0;
    else
      st <= next_st;
    if (push)
      mem[st.wr] <= in_data;
  end
endmodule

// ### hdl/gam_prohibit_timer.sv
// settling timer: counts a prohibit interval scaled by reference frequency
// assumes start is a one-cycle pulse on sys_clk
`timescale 1ns/10ps
module gam_prohibit_timer (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // control
  input  wire logic        start,
  input  wire logic [15:0] cycles,
  input  wire logic [3:0]  ref_freq,
  // status
  output logic             busy
);
  typedef struct packed {
    logic [3:0]  pre;
    logic [15:0] left;
    logic        busy;
  } gam_tmr_st_t;

  gam_tmr_st_t st;
  gam_tmr_st_t next_st;

  assign busy = st.busy;

  // prescale tick every ref_freq+1 cycles stretches timing with slower settings
  always_comb
  begin
    next_st = st;
    if (start)
    begin
      next_st.busy = 1'b1;
      next_st.left = cycles;
      next_st.pre  = ref_freq;
    end
    else if (st.busy)
    begin
      if (st.pre != 4'h0)
        next_st.pre = st.pre - 4'h1;
      else
      begin
        next_st.pre = ref_freq;
        if (st.left <= 16'h0001)
          next_st.busy = 1'b0;
        else
          next_st.left = st.left - 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      st <= '0;
    else
      st <= next_st;
  end
endmodule

// ### hdl/gam_aux_mode.sv
// auxiliary mode configuration and its effect on listener and talker
// assumes host port strobes are synchronous one-cycle pulses on sys_clk
`timescale 1ns/10ps
module gam_aux_mode
  import gam_pkg::*;
(
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 srst,
  // host auxiliary mode port
  input  wire logic                 aux_wr,
  input  wire logic [7:0]           aux_wdata,
  input  wire logic                 eos_wr,
  input  wire logic [7:0]           eos_wdata,
  input  wire logic                 aux_rd,
  output logic [7:0]                aux_rdata,
  // bus side state from the interface functions
  input  wire logic                 talker_active,
  input  wire logic                 poll_active,
  input  wire logic                 srq_state,
  input  wire logic                 poll_flag,
  input  wire logic                 enter_clear,
  input  wire logic                 enter_trigger,
  input  wire logic                 undefined_cmd,
  input  wire logic                 irq_level,
  input  wire logic                 ppoll_req,
  // received byte stream
  input  wire logic                 rx_valid,
  output logic                      rx_ready,
  input  wire logic [7:0]           rx_data,
  input  wire logic                 rx_eoi,
  // host read of received bytes
  output logic                      host_valid,
  input  wire logic                 host_ready,
  output gam_pkg::gam_byte_t        host_byte,
  // transmit byte stream
  input  wire logic                 tx_valid,
  output logic                      tx_ready,
  input  wire logic [7:0]           tx_data,
  output logic                      tx_send,
  output logic [7:0]                tx_bus_data,
  output logic                      tx_end,
  // status and pins
  output logic                      end_flag,
  output logic                      cmd_pass_through_flag,
  output logic                      rfd_hold,
  output logic                      dac_hold,
  output logic                      irq_pin,
  output logic                      ist,
  output logic [7:0]                ppoll_lines
);
  import gam_pkg::*;

  typedef struct packed {
    gam_reg_a_t reg_a;
    gam_reg_b_t reg_b;
    gam_reg_e_t reg_e;
    gam_poll_t  poll;
    logic [3:0] ref_freq;
    logic [7:0] eos;
    logic       end_flag;
    logic       cpt_flag;
    logic       rfd_hold;
    logic       dac_hold;
    logic       irq_pin;
    logic       ist;
    logic [7:0] ppoll_lines;
    logic       tx_started;
    logic       tx_send;
    logic [7:0] tx_bus_data;
    logic       tx_end;
    logic [7:0] rdata;
  } gam_st_t;

  gam_st_t    st;
  gam_st_t    next_st;
  logic [2:0] code;
  logic [4:0] val;
  logic       fifo_in_ready;
  logic       fifo_push;
  gam_byte_t  fifo_in;
  gam_byte_t  fifo_out;
  logic       rx_eos_hit;
  logic       tx_eos_hit;
  logic       tmr_start;
  logic [15:0] tmr_cycles;
  logic       tmr_busy;
  logic       rx_byte_end;

  assign code = aux_wdata[7:5];
  assign val  = aux_wdata[4:0];

  // seven or eight bit compare
  function automatic logic eos_match(input logic [7:0] d, input logic [7:0] e,
                                     input logic w8);
    eos_match = w8 ? (d == e) : (d[6:0] == e[6:0]);
  endfunction

  assign rx_eos_hit  = eos_match(rx_data, st.eos, st.reg_a.eos_width_select);
  assign tx_eos_hit  = eos_match(tx_data, st.eos, st.reg_a.eos_width_select);
  // eos counts as end only when permitted
  assign rx_byte_end = rx_eoi || (rx_eos_hit && st.reg_a.end_on_eos_permit);

  // holding rfd stalls the listener even with fifo room
  assign rx_ready  = fifo_in_ready && !st.rfd_hold;
  assign fifo_push = rx_valid && rx_ready;
  assign fifo_in   = '{end_mark: rx_byte_end, data: rx_data};

  // source handshake waits out T1 after each byte before taking the next
  assign tx_ready   = !tmr_busy && !st.tx_send;
  assign tmr_start  = tx_valid && tx_ready && talker_active;
  // first byte always long T1; fast only from the second
  assign tmr_cycles = (st.reg_b.fast_settle_select && st.tx_started)
                      ? 16'(T1_SHORT_CYC) : 16'(T1_LONG_CYC);

  gam_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (host_valid),
    .out_ready (host_ready),
    .out_data  (fifo_out)
  );

  assign host_byte = fifo_out;

  gam_prohibit_timer u_t1 (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .start    (tmr_start),
    .cycles   (tmr_cycles),
    .ref_freq (st.ref_freq),
    .busy     (tmr_busy)
  );

  always_comb
  begin
    next_st = st;
    // host port decode
    if (aux_wr)
    begin
      unique case (code)
        CODE_REG_A:    next_st.reg_a = gam_reg_a_t'(val);
        CODE_REG_B:    next_st.reg_b = gam_reg_b_t'(val);
        CODE_REG_E:    next_st.reg_e = gam_reg_e_t'(val[1:0]);
        CODE_POLL_CFG: next_st.poll  = gam_poll_t'(val);
        CODE_REF_FREQ: next_st.ref_freq = val[3:0];
        default:       next_st.ref_freq = st.ref_freq;
      endcase
    end
    if (eos_wr)
      next_st.eos = eos_wdata;
    // status read only, config never exposed
    if (aux_rd)
      next_st.rdata = {6'h00, st.dac_hold, st.cpt_flag};

    // end flag: set wins over host read of the byte
    if (host_valid && host_ready)
      next_st.end_flag = 1'b0;
    if (fifo_push && rx_byte_end)
      next_st.end_flag = 1'b1;

    // listener rfd holdoff by receive mode
    if (aux_wr && code == CODE_AUX_CMD && val == CMD_VALID)
      next_st.rfd_hold = 1'b0;
    if (fifo_push)
    begin
      unique case (st.reg_a.receive_mode_high ? {1'b1, st.reg_a.receive_mode_low}
                                              : {1'b0, st.reg_a.receive_mode_low})
        RX_NORMAL:     next_st.rfd_hold = 1'b0;
        RX_HOLD_ALL:   next_st.rfd_hold = 1'b1;
        RX_HOLD_END:   next_st.rfd_hold = rx_byte_end;
        RX_CONTINUOUS: next_st.rfd_hold = 1'b0;
      endcase
    end
    if (!st.reg_a.receive_mode_high && !st.reg_a.receive_mode_low)
      next_st.rfd_hold = 1'b0;

    // pass-through flag; cleared by the valid or non-valid command, set wins
    if (aux_wr && code == CODE_AUX_CMD && (val == CMD_VALID || val == CMD_NONVALID))
      next_st.cpt_flag = 1'b0;
    if (undefined_cmd && st.reg_b.undefined_cmd_detect)
      next_st.cpt_flag = 1'b1;

    // dac holdoff, released by valid/non-valid, new entry wins
    if (aux_wr && code == CODE_AUX_CMD && (val == CMD_VALID || val == CMD_NONVALID))
      next_st.dac_hold = 1'b0;
    if (enter_clear && st.reg_e.clear_holdoff_enable)
      next_st.dac_hold = 1'b1;
    if (enter_trigger && st.reg_e.trigger_holdoff_enable)
      next_st.dac_hold = 1'b1;

    // talker: end with eos when permitted
    next_st.tx_send = 1'b0;
    if (!talker_active)
      next_st.tx_started = 1'b0;
    if (tmr_start)
    begin
      next_st.tx_started  = 1'b1;
      next_st.tx_send     = 1'b1;
      next_st.tx_bus_data = tx_data;
      next_st.tx_end      = tx_eos_hit && st.reg_a.auto_end_permit
                            && (!poll_active || st.reg_b.end_in_poll_permit);
    end

    // interrupt pin polarity
    next_st.irq_pin = irq_level ^ ~st.reg_b.irq_polarity;
    // ist source
    next_st.ist = st.reg_b.ist_source_select ? srq_state : poll_flag;
    // parallel poll answer: sense matched with ist on the selected line
    next_st.ppoll_lines = 8'h00;
    if (ppoll_req && !st.poll.unconfigure && (st.poll.sense == next_st.ist))
      next_st.ppoll_lines[st.poll.poll_line_select] = 1'b1;
  end

  // reset clears all config
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      st          <= '0;
      st.reg_a    <= gam_reg_a_t'(CFG_RESET);
      st.reg_b    <= gam_reg_b_t'(CFG_RESET);
      st.poll     <= gam_poll_t'(CFG_RESET);
      st.ref_freq <= FREQ_RESET;
      st.eos      <= EOS_RESET;
      st.irq_pin  <= 1'b1;
    end
    else
      st <= next_st;
  end

  // write-only config: the read port never exposes it
  assign aux_rdata             = st.rdata;
  assign end_flag              = st.end_flag;
  assign cmd_pass_through_flag = st.cpt_flag;
  assign rfd_hold              = st.rfd_hold;
  assign dac_hold              = st.dac_hold;
  assign irq_pin               = st.irq_pin;
  assign ist                   = st.ist;
  assign ppoll_lines           = st.ppoll_lines;
  assign tx_send               = st.tx_send;
  assign tx_bus_data           = st.tx_bus_data;
  assign tx_end                = st.tx_end;
endmodule

// ### testbench/gam_aux_mode_checker.sv
// checker of the aux mode block: flags, pins, holdoffs, settling
// assumes binding to gam_aux_mode and a single sys_clk domain
`timescale 1ns/10ps
module gam_aux_mode_checker
  import gam_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // host port
  input  wire logic       aux_wr,
  input  wire logic [7:0] aux_wdata,
  input  wire logic       aux_rd,
  input  wire logic [7:0] aux_rdata,
  // bus side causes
  input  wire logic       enter_clear,
  input  wire logic       enter_trigger,
  input  wire logic       undefined_cmd,
  input  wire logic       irq_level,
  input  wire logic       rx_valid,
  input  wire logic       rx_ready,
  input  wire logic       tx_ready,
  input  wire logic       tx_send,
  // watched outputs
  input  wire logic       cmd_pass_through_flag,
  input  wire logic       rfd_hold,
  input  wire logic       dac_hold,
  input  wire logic       irq_pin
);
  logic [4:0] ra;
  logic [4:0] rb;
  logic [1:0] re;

  // shadow of the write-only config, same edge as the design
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ra <= CFG_RESET;
      rb <= CFG_RESET;
      re <= 2'h0;
    end
    else if (aux_wr)
    begin
      if (aux_wdata[7:5] == CODE_REG_A)
        ra <= aux_wdata[4:0];
      if (aux_wdata[7:5] == CODE_REG_B)
        rb <= aux_wdata[4:0];
      if (aux_wdata[7:5] == CODE_REG_E)
        re <= aux_wdata[1:0];
    end
  end

  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  cpt_set_a: assert property (undefined_cmd && rb[0] |=> cmd_pass_through_flag)
    else $error("pass-through flag not set");
  cpt_quiet_a: assert property (undefined_cmd && !rb[0] && !cmd_pass_through_flag
    |=> !cmd_pass_through_flag)
    else $error("pass-through flag set while detection off");
  irq_level_a: assert property (!$past(srst) |-> irq_pin == ($past(irq_level) ^ !$past(rb[3])))
    else $error("interrupt pin level wrong");
  clear_hold_a: assert property (enter_clear && re[0] |=> dac_hold)
    else $error("no accept holdoff on clear");
  trig_hold_a: assert property (enter_trigger && re[1] |=> dac_hold)
    else $error("no accept holdoff on trigger");
  hold_release_a: assert property (aux_wr && aux_wdata == 8'h0F && !enter_clear
    && !enter_trigger |=> !dac_hold)
    else $error("accept holdoff not released");
  read_hide_a: assert property (aux_rd |=> aux_rdata[7:2] == 6'h00)
    else $error("config visible on read");
  hold_all_a: assert property (rx_valid && rx_ready && ra[1:0] == RX_HOLD_ALL
    |=> rfd_hold && !rx_ready)
    else $error("ready not held after byte");
  settle_a: assert property (tx_send |=> !tx_ready [*8])
    else $error("send accepted inside settling time");
endmodule

// ### testbench/gam_bus_partner.sv
// bus-side instrument model offering received bytes to the listener
// assumes go is a one-cycle pulse from the bench on sys_clk
`timescale 1ns/10ps
module gam_bus_partner (
  // clock
  input  wire logic       sys_clk,
  // bench request
  input  wire logic       go,
  input  wire logic [7:0] byte_in,
  input  wire logic       eoi_in,
  input  wire logic [3:0] lag,
  output logic            idle,
  // listener stream
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic [7:0]      rx_data,
  output logic            rx_eoi
);
  logic       pend = 1'b0;
  logic [3:0] cnt  = 4'h0;

  initial
  begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    rx_eoi   = 1'b0;
  end
  assign idle = !pend && !rx_valid;

  // lag lets the model answer slowly as well as promptly
  always @(posedge sys_clk)
  begin
    if (go)
    begin
      pend    <= 1'b1;
      cnt     <= lag;
      rx_data <= byte_in;
      rx_eoi  <= eoi_in;
    end
    else if (pend && cnt != 4'h0)
      cnt <= cnt - 4'h1;
    else if (pend)
    begin
      pend     <= 1'b0;
      rx_valid <= 1'b1;
    end
    else if (rx_valid && rx_ready)
    begin
      rx_valid <= 1'b0;
      // released lines must not keep showing the old byte
      rx_data  <= ~rx_data;
      rx_eoi   <= ~rx_eoi;
    end
  end
endmodule

// ### testbench/tb_gam_aux_mode.sv
// self-checking bench of the aux mode block with a bus partner model
// assumes gam_pkg compiled first and a 125 MHz sys_clk
`timescale 1ns/10ps
module tb_gam_aux_mode;
  import gam_pkg::*;
  logic sys_clk = 1'b0, srst = 1'b1, aux_wr = 1'b0, eos_wr = 1'b0, aux_rd = 1'b0;
  logic [7:0] aux_wdata = 8'h00, eos_wdata = 8'h00, tx_data = 8'h00, pbyte = 8'h00;
  logic talker_active = 1'b0, srq_state = 1'b0, poll_flag = 1'b0, enter_clear = 1'b0;
  logic enter_trigger = 1'b0, undefined_cmd = 1'b0, irq_level = 1'b0, ppoll_req = 1'b0;
  logic host_ready = 1'b0, tx_valid = 1'b0, go = 1'b0, peoi = 1'b0, poll_active = 1'b0;
  logic [3:0] lag = 4'h0;
  logic [7:0] aux_rdata, tx_bus_data, ppoll_lines, rx_data, first;
  logic rx_valid, rx_ready, rx_eoi, host_valid, tx_ready, tx_send, tx_end, end_flag;
  logic cmd_pass_through_flag, rfd_hold, dac_hold, irq_pin, ist, idle;
  gam_byte_t host_byte;
  logic [7:0] rnd = 8'h3C;
  logic [4:0] atab [4] = '{5'h04, 5'h00, 5'h04, 5'h14};
  logic [7:0] dtab [4] = '{8'hA5, 8'hA5, 8'h25, 8'h25};
  int n_tests = 0, n_mismatch = 0, gap = 0, cnt = 0;

  always #4 sys_clk = ~sys_clk;

  gam_aux_mode gam_aux_mode_inst (.sys_clk, .srst, .aux_wr, .aux_wdata, .eos_wr, .eos_wdata,
    .aux_rd, .aux_rdata, .talker_active, .poll_active, .srq_state, .poll_flag,
    .enter_clear, .enter_trigger, .undefined_cmd, .irq_level, .ppoll_req, .rx_valid,
    .rx_ready, .rx_data, .rx_eoi, .host_valid, .host_ready, .host_byte, .tx_valid,
    .tx_ready, .tx_data, .tx_send, .tx_bus_data, .tx_end, .end_flag, .cmd_pass_through_flag,
    .rfd_hold, .dac_hold, .irq_pin, .ist, .ppoll_lines);
  gam_bus_partner gam_bus_partner_inst (.sys_clk, .go, .byte_in(pbyte), .eoi_in(peoi),
    .lag, .idle, .rx_valid, .rx_ready, .rx_data, .rx_eoi);

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic exp_end(input logic [4:0] a, input logic [7:0] e, d);
    return a[2] && (a[4] ? d == e : d[6:0] == e[6:0]);
  endfunction

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic timeout();
    n_mismatch++;
    $display("wait bound used up at %0t", $time);
    print_verdict();
  endtask
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic aux(input logic [7:0] v);
    aux_wr = 1'b1;
    aux_wdata = v;
    tick();
    aux_wr = 1'b0;
    // one idle edge keeps back-to-back writes apart
    tick();
  endtask
  task automatic rx_send(input logic [7:0] b, input logic e);
    rnd = lfsr(rnd);
    lag = {1'b0, rnd[2:0]};
    pbyte = b;
    peoi = e;
    go = 1'b1;
    tick();
    go = 1'b0;
    for (int i = 0; i < 40 && !idle; i++)
      tick();
    if (!idle)
      timeout();
    tick();
  endtask
  task automatic drain();
    host_ready = 1'b1;
    repeat (10) tick();
    host_ready = 1'b0;
  endtask
  task automatic tx_byte(input logic [7:0] b);
    tick();
    tx_valid = 1'b1;
    tx_data = b;
    for (gap = 0; gap < 600 && !tx_ready; gap++)
      tick();
    if (!tx_ready)
      timeout();
    tick();
    tx_valid = 1'b0;
    for (int i = 0; i < 3 && tx_send !== 1'b1; i++)
      tick();
    if (tx_send !== 1'b1)
      timeout();
    chk_byte(tx_bus_data, b);
  endtask

  initial
  begin
    repeat (3) tick();
    srst = 1'b0;
    chk_byte({end_flag, cmd_pass_through_flag, dac_hold, rfd_hold, irq_pin}, 8'h01);
    aux({CODE_REG_B, 5'h1F});
    aux_rd = 1'b1;
    tick();
    aux_rd = 1'b0;
    chk_byte(aux_rdata, 8'h00);
    done("reset and read");
    for (int k = 0; k < 8; k++)
    begin
      rnd = lfsr(rnd);
      aux({CODE_REG_B, rnd[4:3], 3'h0});
      irq_level = rnd[0];
      srq_state = rnd[1];
      poll_flag = rnd[2];
      tick();
      chk_bit(irq_pin, rnd[0] ^ !rnd[3]);
      chk_bit(ist, rnd[4] ? rnd[1] : rnd[2]);
    end
    done("pin and ist");
    for (int k = 0; k < 2; k++)
    begin
      aux({CODE_REG_B, 4'h0, k[0]});
      undefined_cmd = 1'b1;
      tick();
      undefined_cmd = 1'b0;
      chk_bit(cmd_pass_through_flag, k[0]);
      aux({CODE_AUX_CMD, k[0] ? CMD_VALID : CMD_NONVALID});
      chk_bit(cmd_pass_through_flag, 1'b0);
    end
    for (int k = 0; k < 4; k++)
    begin
      aux({CODE_REG_E, 3'h0, k[1:0]});
      enter_clear = 1'b1;
      tick();
      enter_clear = 1'b0;
      chk_bit(dac_hold, k[0]);
      aux({CODE_AUX_CMD, CMD_NONVALID});
      enter_trigger = 1'b1;
      tick();
      enter_trigger = 1'b0;
      chk_bit(dac_hold, k[1]);
      aux({CODE_AUX_CMD, CMD_VALID});
      chk_bit(dac_hold, 1'b0);
    end
    done("holdoffs");
    for (int k = 0; k < 4; k++)
    begin
      aux({CODE_REG_A, 3'h0, k[1:0]});
      rx_send(8'h11, k == 2);
      chk_bit(rfd_hold, k == 1 || k == 2);
      aux({CODE_AUX_CMD, CMD_VALID});
      drain();
    end
    eos_wr = 1'b1;
    eos_wdata = 8'hA5;
    tick();
    eos_wr = 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      aux({CODE_REG_A, atab[k]});
      rx_send(dtab[k], 1'b0);
      chk_bit(end_flag, exp_end(atab[k], 8'hA5, dtab[k]));
      drain();
    end
    done("receive modes");
    aux({CODE_REG_A, 5'h00});
    for (int k = 0; k < 8; k++)
    begin
      if (k == 0)
        first = rnd;
      rx_send(rnd, 1'b0);
    end
    chk_bit(rx_ready, 1'b0);
    chk_byte(host_byte.data, first);
    cnt = 0;
    host_ready = 1'b1;
    repeat (12)
    begin
      cnt += int'(host_valid);
      tick();
    end
    host_ready = 1'b0;
    chk_byte(cnt[7:0], 8'h08);
    done("fifo");
    talker_active = 1'b1;
    aux({CODE_REF_FREQ, 5'h00});
    aux({CODE_REG_A, 5'h08});
    aux({CODE_REG_B, 5'h04});
    tx_byte(8'hA5);
    chk_bit(tx_end, 1'b1);
    tx_byte(8'h3C);
    chk_bit(tx_end, 1'b0);
    chk_bit(gap > T1_LONG_CYC - 8, 1'b1);
    tx_byte(8'h5A);
    chk_bit(gap < T1_SHORT_CYC + 8, 1'b1);
    aux({CODE_REG_B, 5'h00});
    tx_byte(8'h66);
    tx_byte(8'h77);
    chk_bit(gap > T1_LONG_CYC - 8, 1'b1);
    aux({CODE_REF_FREQ, 5'h01});
    tx_byte(8'h88);
    tx_byte(8'h99);
    chk_bit(gap > 2 * T1_LONG_CYC - 8, 1'b1);
    poll_active = 1'b1;
    tx_byte(8'hA5);
    chk_bit(tx_end, 1'b0);
    aux({CODE_REG_B, 5'h02});
    tx_byte(8'hA5);
    chk_bit(tx_end, 1'b1);
    poll_active = 1'b0;
    talker_active = 1'b0;
    done("transmit");
    poll_flag = 1'b1;
    ppoll_req = 1'b1;
    for (int k = 0; k < 9; k++)
    begin
      aux({CODE_POLL_CFG, k[3], 1'b1, k[2:0]});
      tick();
      chk_byte(ppoll_lines, k[3] ? 8'h00 : 8'h01 << k[2:0]);
    end
    done("parallel poll");
    aux({CODE_REG_B, 5'h08});
    irq_level = 1'b1;
    srst = 1'b1;
    repeat (2) tick();
    srst = 1'b0;
    tick();
    chk_bit(irq_pin, 1'b0);
    done("mid-run reset");
    print_verdict();
  end
endmodule

bind gam_aux_mode gam_aux_mode_checker gam_aux_mode_checker_inst (.sys_clk, .srst, .aux_wr,
  .aux_wdata, .aux_rd, .aux_rdata, .enter_clear, .enter_trigger, .undefined_cmd, .irq_level,
  .rx_valid, .rx_ready, .tx_ready, .tx_send, .cmd_pass_through_flag, .rfd_hold, .dac_hold,
  .irq_pin);
